// >>> logic/spisd_params.svh
`ifndef SPISD_PARAMS_SVH
`define SPISD_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets, data space
// ----------------------------------------------------------------
`define SPISD_P0_STATUS_OFS 8'h4d
`define SPISD_P0_DATA_OFS 8'h4e
`define SPISD_P1_STATUS_OFS 8'had
`define SPISD_P1_DATA_OFS 8'hae
// io instructions address data space minus this
`define SPISD_IO_BIAS 8'h20
`define SPISD_IO_TOP 8'h3f

// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define SPISD_DONE_BIT 7
`define SPISD_WCOL_BIT 6
`define SPISD_DBL_BIT 0
`define SPISD_STATUS_RESET 8'h00

// ----------------------------------------------------------------
// serial clock divisors of the system clock
// ----------------------------------------------------------------
`define SPISD_DIV_N0 8'h04
`define SPISD_DIV_N1 8'h10
`define SPISD_DIV_N2 8'h40
`define SPISD_DIV_N3 8'h80
`define SPISD_DIV_D0 8'h02
`define SPISD_DIV_D1 8'h08
`define SPISD_DIV_D2 8'h20
`define SPISD_DIV_D3 8'h40
// clock edges in one byte exchange, minus one
`define SPISD_LAST_EDGE 4'hf

`endif

// >>> logic/spisd_pkg.sv
package spisd_pkg;
  // master transfer sequencing
  typedef enum logic {XFER_IDLE, XFER_RUN} spisd_state_type;
endpackage : spisd_pkg

// >>> logic/spisd_status_data.sv
`timescale 1ns/10ps
`include "spisd_params.svh"

// Operation
// [R1] master with double speed set runs serial clock at twice selected rate
// [R2] fastest master serial clock period is two system clock periods
// [R3] external master keeps serial clock at most a quarter of system clock
// [R4] transfer-done flag, status bit 7, sets when a byte exchange finishes
// [R5] interrupt request while done flag, port irq enable and global enable
// [R6] select input low in master mode also sets the done flag
// [R7] done flag clears when the processor takes the interrupt vector
// [R8] status read with flag set then data access clears the flag
// [R9] data write during an exchange sets collision flag, status bit 6
// [R10] status read seeing collision then data access clears both flags
// [R11] data write loads shift register and starts an exchange
// [R12] data read returns receive buffer, the last byte shifted in
// [R13] io address is data-space offset minus 0x20, inside 0x00 to 0x3f
// [R14] full duplex: eight bits out while eight in, copied at completion
// [R15] master divisor 4,16,64,128 or 2,8,32,64 with double speed
// [R16] select input low in master mode drops master select
// [R17] nothing transfers unless the port enable bit is one
// [R18] polarity sets idle level, phase picks sample or setup edge first
module spisd_status_data
  import spisd_pkg::*;
#(
  parameter bit PORT_ONE = 1'b1 // which of the two ports this is
) (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] busAddr, // register address
  input wire logic busIoSpace, // address given in io space
  input wire logic busWrite, // write strobe
  input wire logic busRead, // read strobe
  input wire logic [7:0] busWdata, // write data
  output logic [7:0] busRdata, // read data, next cycle
  input wire logic portEnable, // control: port enable
  input wire logic controllerSelect, // control: master mode
  input wire logic idleClockLevel, // control: clock polarity
  input wire logic sampleEdgeSelect, // control: clock phase
  input wire logic [1:0] rateSelect, // control: rate field
  input wire logic xferIrqEnable, // control: interrupt enable
  input wire logic globalIrqEnable, // core global interrupt enable
  input wire logic irqVectorAck, // core takes this vector
  output logic xferIrq, // interrupt request
  output logic controllerSelectClear, // pulse: drop master select
  input wire logic ssIsInput, // select pin is an input
  input wire logic ssIn_n, // select pin level, active low
  input wire logic sckIn, // serial clock pin in
  output logic sckOut, // serial clock pin out
  output logic sckOe, // serial clock drive enable
  input wire logic serialIn, // data in (miso or mosi)
  output logic serialOut, // data out
  output logic serialOe // data out drive enable
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = PORT_ONE ? `SPISD_P1_STATUS_OFS : `SPISD_P0_STATUS_OFS;
  localparam logic [7:0] DATA_OFS = PORT_ONE ? `SPISD_P1_DATA_OFS : `SPISD_P0_DATA_OFS;
  localparam logic [7:0] STATUS_RST = `SPISD_STATUS_RESET;

  // map io-space address into data space
  function automatic logic [7:0] dataSpaceAddr(input logic [7:0] a, input logic io);
    // [R13] io offset bias
    if (io) begin
      return (a <= `SPISD_IO_TOP) ? 8'(a + `SPISD_IO_BIAS) : 8'h00;
    end
    return a;
  endfunction : dataSpaceAddr

  // half serial clock period in system clocks
  function automatic logic [6:0] halfPeriod(input logic dbl, input logic [1:0] rate);
    logic [7:0] div;
    div = `SPISD_DIV_N0;
    // [R15] rate table
    unique case ({dbl, rate})
      3'b000: div = `SPISD_DIV_N0;
      3'b001: div = `SPISD_DIV_N1;
      3'b010: div = `SPISD_DIV_N2;
      3'b011: div = `SPISD_DIV_N3;
      3'b100: div = `SPISD_DIV_D0;
      3'b101: div = `SPISD_DIV_D1;
      3'b110: div = `SPISD_DIV_D2;
      3'b111: div = `SPISD_DIV_D3;
    endcase
    return div[7:1];
  endfunction : halfPeriod

  logic [7:0] effAddr;
  logic statusRead, dataRead, dataWrite, dataAccess;
  assign effAddr = dataSpaceAddr(busAddr, busIoSpace);
  assign statusRead = busRead && (effAddr == STATUS_OFS);
  assign dataRead = busRead && (effAddr == DATA_OFS);
  assign dataWrite = busWrite && (effAddr == DATA_OFS);
  assign dataAccess = dataRead || dataWrite;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spisd_state_type state_reg, state_next;
  logic [6:0] halfCnt_reg, halfCnt_next;
  logic [3:0] edgeCnt_reg, edgeCnt_next;
  logic [7:0] shiftReg_reg, shiftReg_next;
  logic [7:0] rxShift_reg, rxShift_next;
  logic [7:0] rxBuf_reg, rxBuf_next;
  logic [7:0] rdata_reg, rdata_next;
  logic sck_reg, sck_next;
  logic sckPrev_reg, sckPrev_next;
  logic xferDoneFlag_reg, xferDoneFlag_next;
  logic writeCollision_reg, writeCollision_next;
  logic doubleSpeed_reg, doubleSpeed_next;
  logic armDone_reg, armDone_next;
  logic armWcol_reg, armWcol_next;

  logic isMaster, slaveActive, busy, modeFault;
  logic masterEdge, slaveEdge, procEdge, leadEdge, doSample, doSetup, doneEvt;
  logic [7:0] rxShiftIn;

  // mode, edge and event decode
  always_comb begin
    // [R17] enable gates everything
    isMaster = portEnable && controllerSelect;
    slaveActive = portEnable && !controllerSelect && !ssIn_n;
    busy = (state_reg == XFER_RUN) || (edgeCnt_reg != 4'h0);
    // [R6] mode fault detect
    modeFault = isMaster && ssIsInput && !ssIn_n;
    // [R1] divider counts the selected half period
    masterEdge = (state_reg == XFER_RUN) && (halfCnt_reg == 7'(halfPeriod(doubleSpeed_reg, rateSelect) - 7'h01));
    // [R3] slave clock taken as synchronous, edge per change
    slaveEdge = slaveActive && (sckIn != sckPrev_reg);
    procEdge = isMaster ? (masterEdge && !modeFault) : slaveEdge;
    leadEdge = !edgeCnt_reg[0];
    // [R18] phase picks which edge samples
    doSample = procEdge && (leadEdge != sampleEdgeSelect);
    doSetup = procEdge && (leadEdge == sampleEdgeSelect);
    rxShiftIn = {rxShift_reg[6:0], serialIn};
    doneEvt = procEdge && (edgeCnt_reg == `SPISD_LAST_EDGE);
  end

  // next-state logic for transfer and registers
  always_comb begin
    state_next = state_reg;
    halfCnt_next = halfCnt_reg;
    edgeCnt_next = edgeCnt_reg;
    shiftReg_next = shiftReg_reg;
    rxShift_next = rxShift_reg;
    rxBuf_next = rxBuf_reg;
    rdata_next = rdata_reg;
    sck_next = sck_reg;
    sckPrev_next = sckIn;
    xferDoneFlag_next = xferDoneFlag_reg;
    writeCollision_next = writeCollision_reg;
    doubleSpeed_next = doubleSpeed_reg;
    armDone_next = armDone_reg;
    armWcol_next = armWcol_reg;
    // master clock divider and pin level
    if (state_reg == XFER_RUN) begin
      halfCnt_next = masterEdge ? 7'h00 : 7'(halfCnt_reg + 7'h01);
      if (masterEdge) begin
        sck_next = !sck_reg;
      end
    end else begin
      halfCnt_next = 7'h00;
      // [R18] idle level from polarity
      sck_next = idleClockLevel;
    end
    // [R14] full duplex shifting
    if (doSample) begin
      rxShift_next = rxShiftIn;
    end
    if (doSetup && !(sampleEdgeSelect && edgeCnt_reg == 4'h0)) begin
      shiftReg_next = {shiftReg_reg[6:0], 1'b0};
    end
    if (procEdge) begin
      edgeCnt_next = 4'(edgeCnt_reg + 4'h1);
    end
    if (doneEvt) begin
      rxBuf_next = doSample ? rxShiftIn : rxShift_reg;
      state_next = XFER_IDLE;
    end
    // slave deselected or port off aborts a partial byte
    if (!isMaster && !slaveActive) begin
      edgeCnt_next = 4'h0;
    end
    // [R16] mode fault aborts master exchange
    if (modeFault || !isMaster) begin
      state_next = XFER_IDLE;
    end
    // aborted byte must not leave the port busy
    if (modeFault) begin
      edgeCnt_next = 4'h0;
    end
    // status and flag clearing by read then data access
    if (statusRead) begin
      armDone_next = xferDoneFlag_reg;
      armWcol_next = writeCollision_reg;
    end
    if (dataAccess) begin
      // [R8] clear on status read then data access
      if (armDone_reg || armWcol_reg) begin
        xferDoneFlag_next = 1'b0;
      end
      // [R10] collision clears both
      if (armWcol_reg) begin
        writeCollision_next = 1'b0;
      end
      armDone_next = 1'b0;
      armWcol_next = 1'b0;
    end
    // [R7] vector clears done flag
    if (irqVectorAck) begin
      xferDoneFlag_next = 1'b0;
    end
    // status write touches only double speed bit
    if (busWrite && effAddr == STATUS_OFS) begin
      doubleSpeed_next = busWdata[`SPISD_DBL_BIT];
    end
    // data write: load or collide
    if (dataWrite) begin
      if (busy) begin
        // [R9] write during exchange collides
        writeCollision_next = 1'b1;
      end else begin
        // [R11] load and start
        shiftReg_next = busWdata;
        edgeCnt_next = 4'h0;
        if (isMaster && !modeFault) begin
          state_next = XFER_RUN;
        end
      end
    end
    // [R4] completion sets the flag, winning over clears
    if (doneEvt || modeFault) begin
      xferDoneFlag_next = 1'b1;
    end
    // read data mux
    if (statusRead) begin
      rdata_next = 8'h00;
      rdata_next[`SPISD_DONE_BIT] = xferDoneFlag_reg;
      rdata_next[`SPISD_WCOL_BIT] = writeCollision_reg;
      rdata_next[`SPISD_DBL_BIT] = doubleSpeed_reg;
    end else if (dataRead) begin
      // [R12] read returns receive buffer
      rdata_next = rxBuf_reg;
    end
  end

  // register all state
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= XFER_IDLE;
      halfCnt_reg <= 7'h00;
      edgeCnt_reg <= 4'h0;
      shiftReg_reg <= 8'h00;
      rxShift_reg <= 8'h00;
      rxBuf_reg <= 8'h00;
      rdata_reg <= 8'h00;
      sck_reg <= 1'b0;
      sckPrev_reg <= 1'b0;
      xferDoneFlag_reg <= STATUS_RST[`SPISD_DONE_BIT];
      writeCollision_reg <= STATUS_RST[`SPISD_WCOL_BIT];
      doubleSpeed_reg <= STATUS_RST[`SPISD_DBL_BIT];
      armDone_reg <= 1'b0;
      armWcol_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      halfCnt_reg <= halfCnt_next;
      edgeCnt_reg <= edgeCnt_next;
      shiftReg_reg <= shiftReg_next;
      rxShift_reg <= rxShift_next;
      rxBuf_reg <= rxBuf_next;
      rdata_reg <= rdata_next;
      sck_reg <= sck_next;
      sckPrev_reg <= sckPrev_next;
      xferDoneFlag_reg <= xferDoneFlag_next;
      writeCollision_reg <= writeCollision_next;
      doubleSpeed_reg <= doubleSpeed_next;
      armDone_reg <= armDone_next;
      armWcol_reg <= armWcol_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // [R5] interrupt gating
  assign xferIrq = xferDoneFlag_reg && xferIrqEnable && globalIrqEnable;
  // [R16] master select drop pulse
  assign controllerSelectClear = modeFault;
  assign busRdata = rdata_reg;
  assign sckOut = sck_reg;
  // [R17] pins driven only when enabled
  assign sckOe = isMaster;
  assign serialOut = shiftReg_reg[7];
  assign serialOe = isMaster || slaveActive;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  done_sets_flag_a: assert property (@(posedge mclk) disable iff (rst) // [R4]
    doneEvt |=> xferDoneFlag_reg) else $error("done flag not set after exchange");
  irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // [R5]
    xferIrq |-> xferDoneFlag_reg && xferIrqEnable && globalIrqEnable) else $error("irq without cause");
  mode_fault_a: assert property (@(posedge mclk) disable iff (rst) // [R6]
    modeFault |-> controllerSelectClear ##1 (xferDoneFlag_reg && state_reg == XFER_IDLE))
    else $error("mode fault not handled");
  vector_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R7]
    irqVectorAck && !doneEvt && !modeFault |=> !xferDoneFlag_reg) else $error("vector did not clear flag");
  flag_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R8]
    statusRead && xferDoneFlag_reg ##[1:3] (dataRead && !doneEvt && !modeFault && !irqVectorAck)
    |=> !xferDoneFlag_reg) else $error("read sequence did not clear flag");
  wcol_set_a: assert property (@(posedge mclk) disable iff (rst) // [R9]
    dataWrite && busy |=> writeCollision_reg && $stable(shiftReg_reg)) else $error("collision missed");
  wcol_clear_a: assert property (@(posedge mclk) disable iff (rst) // [R10]
    statusRead && writeCollision_reg ##[1:3] (dataRead && !doneEvt && !modeFault)
    |=> !writeCollision_reg && !xferDoneFlag_reg) else $error("collision not cleared");
  load_start_a: assert property (@(posedge mclk) disable iff (rst) // [R11]
    dataWrite && !busy |=> shiftReg_reg == $past(busWdata)) else $error("write did not load");
  read_rx_a: assert property (@(posedge mclk) disable iff (rst) // [R12]
    dataRead |=> busRdata == $past(rxBuf_reg)) else $error("data read not receive buffer");
  fast_edge_a: assert property (@(posedge mclk) disable iff (rst) // [R2]
    state_reg == XFER_RUN && doubleSpeed_reg && rateSelect == 2'b00 && !modeFault
    && !doneEvt && isMaster |-> masterEdge) else $error("double speed period not two clocks");
  slow_edge_a: assert property (@(posedge mclk) disable iff (rst) // [R15]
    masterEdge && !doubleSpeed_reg && rateSelect == 2'b11 |=> !masterEdge [*8])
    else $error("divide by 128 too fast");
  enable_off_a: assert property (@(posedge mclk) disable iff (rst) // [R17]
    !portEnable |-> !sckOe && !serialOe && !procEdge) else $error("transfer while disabled");
  idle_level_a: assert property (@(posedge mclk) disable iff (rst) // [R18]
    state_reg == XFER_IDLE && $stable(idleClockLevel) ##1 state_reg == XFER_IDLE
    |-> sckOut == $past(idleClockLevel)) else $error("idle clock level wrong");
  duplex_a: assert property (@(posedge mclk) disable iff (rst) // [R14]
    doneEvt && sampleEdgeSelect |=> rxBuf_reg == $past(rxShiftIn)) else $error("received byte lost");
  io_map_a: assert property (@(posedge mclk) disable iff (rst) // [R13]
    busRead && busIoSpace && busAddr == 8'(STATUS_OFS - `SPISD_IO_BIAS) |-> statusRead)
    else $error("io address mapping wrong");

  master_done_c: cover property (@(posedge mclk) disable iff (rst) doneEvt && isMaster);
  slave_done_c: cover property (@(posedge mclk) disable iff (rst) doneEvt && slaveActive);
  collision_c: cover property (@(posedge mclk) disable iff (rst) dataWrite && busy);
  mode_fault_c: cover property (@(posedge mclk) disable iff (rst) modeFault);

endmodule : spisd_status_data

// >>> tb/spisd_slave_model.sv
`timescale 1ns/10ps
module spisd_slave_model (
  input wire logic mclk, // system clock
  input wire logic sck, // serial clock from master
  input wire logic mosi, // data from master
  input wire logic active, // selected for one byte
  input wire logic sample_edge_select, // phase setting
  input wire logic [7:0] txByte, // byte to return
  output logic miso, // data to master
  output logic [7:0] rxByte // byte collected
);
  logic [7:0] txSh;
  logic [3:0] edgeNo;
  logic junk = 1'b0;
  // ----------------------------------------------------------------
  // byte shifter
  // ----------------------------------------------------------------
  // load reply when selected
  always @(posedge active) begin
    txSh = txByte;
    edgeNo = 4'h0;
  end
  // sample or setup edge per phase
  always @(sck) begin
    if (active) begin
      if (edgeNo[0] == sample_edge_select) begin
        rxByte = {rxByte[6:0], mosi};
      end else if (edgeNo != 4'h0) begin
        txSh = {txSh[6:0], 1'b0};
      end
      edgeNo = edgeNo + 4'h1;
    end
  end
  // released line changes every cycle
  always @(posedge mclk) junk <= ~junk;
  assign miso = active ? txSh[7] : junk;
endmodule : spisd_slave_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0, rst = 1'b1, busIoSpace = 1'b0, busWrite = 1'b0, busRead = 1'b0;
  logic [7:0] busAddr = 8'h00, busWdata = 8'h00, busRdata, pTx = 8'h00, pRx, d, r;
  logic portEnable = 1'b1, controllerSelect = 1'b1, idleClockLevel = 1'b0, sampleEdgeSelect = 1'b0;
  logic [1:0] rateSelect = 2'h0;
  logic xferIrqEnable = 1'b1, globalIrqEnable = 1'b1, irqVectorAck = 1'b0, xferIrq, msClr;
  logic ssIsInput = 1'b0, ssIn_n = 1'b1, sckOut, sckOe, serialOut, serialOe, miso, act = 1'b0;
  logic [1:0] rdAge = 2'h0;
  logic sIn = 1'b0, sdi = 1'b0;
  logic [7:0] rb, got;
  logic [7:0] expQ [$];
  logic [7:0] halves [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
  int nMismatch = 0, totalChecks = 0, cyc = 0, seed = 52, i;
  always #2 mclk = ~mclk;
  spisd_status_data #(.PORT_ONE(1'b0)) i_spisd_status_data (.mclk(mclk), .rst(rst), .busAddr(busAddr),
    .busIoSpace(busIoSpace), .busWrite(busWrite), .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata),
    .portEnable(portEnable), .controllerSelect(controllerSelect), .idleClockLevel(idleClockLevel),
    .sampleEdgeSelect(sampleEdgeSelect), .rateSelect(rateSelect), .xferIrqEnable(xferIrqEnable),
    .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck), .xferIrq(xferIrq),
    .controllerSelectClear(msClr), .ssIsInput(ssIsInput), .ssIn_n(ssIn_n), .sckIn(sIn), .sckOut(sckOut),
    .sckOe(sckOe), .serialIn(controllerSelect ? miso : sdi), .serialOut(serialOut), .serialOe(serialOe));
  spisd_slave_model i_spisd_slave_model (.mclk(mclk), .sck(sckOut), .mosi(serialOut), .active(act),
    .sample_edge_select(sampleEdgeSelect), .txByte(pTx), .miso(miso), .rxByte(pRx));
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] e, input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // read results leave the queue two edges after the strobe
  always @(posedge mclk) rdAge <= {rdAge[0], busRead};
  always @(negedge mclk) if (rdAge[1]) check(expQ.pop_front(), busRdata);
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      tally_and_finish;
    end
  end
  // ----------------------------------------------------------------
  // bus and link tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] v, input logic isIo);
    @(negedge mclk);
    busAddr = a;
    busIoSpace = isIo;
    busWdata = v;
    busWrite = 1'b1;
    @(negedge mclk);
    busWrite = 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic isIo, input logic [7:0] e);
    @(negedge mclk);
    busAddr = a;
    busIoSpace = isIo;
    busRead = 1'b1;
    expQ.push_back(e);
    @(negedge mclk);
    busRead = 1'b0;
    @(negedge mclk);
  endtask : bus_rd
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cycles
  // byte exchange, spacing of clock edges and count measured
  task automatic xfer(input logic [7:0] half);
    int n, tog, gap;
    logic last;
    n = 0;
    tog = 0;
    gap = 0;
    pTx = r;
    act = 1'b1;
    bus_wr(8'h4e, d, 1'b0);
    last = sckOut;
    while (xferIrq !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
      gap++;
      if (sckOut !== last) begin
        if (tog > 0) check(half, 8'(gap));
        tog++;
        gap = 0;
        last = sckOut;
      end
    end
    act = 1'b0;
    check(8'h10, 8'(tog));
    check(d, pRx);
    check({7'h0, idleClockLevel}, {7'h0, sckOut});
  endtask : xfer
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_cycles(6);
    rst = 1'b0;
    bus_rd(8'h4d, 1'b0, 8'h00);
    bus_rd(8'h4e, 1'b0, 8'h00);
    bus_wr(8'h2d, 8'hff, 1'b1);
    bus_rd(8'h2d, 1'b1, 8'h01);
    bus_rd(8'h4f, 1'b0, 8'h01);
    $display("reset and access test done");
    for (i = 0; i < 8; i++) begin
      idleClockLevel = i[0];
      sampleEdgeSelect = i[1];
      rateSelect = i[1:0];
      bus_wr(8'h2d, {7'h0, i[2]}, 1'b1);
      d = 8'($random(seed));
      r = 8'($random(seed));
      xfer(halves[i]);
      check(8'h01, {7'h0, xferIrq});
      bus_rd(8'h4d, 1'b0, {7'h40, i[2]});
      bus_rd(8'h4e, 1'b0, r);
      bus_rd(8'h4d, 1'b0, {7'h0, i[2]});
    end
    $display("rate and mode test done");
    act = 1'b1;
    pTx = r;
    bus_wr(8'h4e, d, 1'b0);
    bus_wr(8'h4e, 8'h5a, 1'b0);
    bus_rd(8'h4d, 1'b0, 8'h41);
    for (i = 0; i < 3000 && xferIrq !== 1'b1; i++) @(negedge mclk);
    act = 1'b0;
    check(d, pRx);
    bus_rd(8'h4d, 1'b0, 8'hc1);
    bus_rd(8'h4e, 1'b0, r);
    bus_rd(8'h4d, 1'b0, 8'h01);
    $display("collision test done");
    globalIrqEnable = 1'b0;
    act = 1'b1;
    bus_wr(8'h4e, d, 1'b0);
    wait_cycles(600);
    act = 1'b0;
    check(8'h00, {7'h0, xferIrq});
    bus_rd(8'h4d, 1'b0, 8'h81);
    globalIrqEnable = 1'b1;
    @(negedge mclk);
    check(8'h01, {7'h0, xferIrq});
    irqVectorAck = 1'b1;
    @(negedge mclk);
    irqVectorAck = 1'b0;
    bus_rd(8'h4d, 1'b0, 8'h01);
    $display("interrupt test done");
    ssIsInput = 1'b1;
    ssIn_n = 1'b0;
    wait_cycles(2);
    check(8'h01, {7'h0, msClr});
    controllerSelect = 1'b0;
    ssIn_n = 1'b1;
    bus_rd(8'h4d, 1'b0, 8'h81);
    bus_rd(8'h4e, 1'b0, r);
    bus_rd(8'h4d, 1'b0, 8'h01);
    $display("mode fault test done");
    controllerSelect = 1'b1;
    ssIsInput = 1'b0;
    portEnable = 1'b0;
    bus_wr(8'h4e, d, 1'b0);
    wait_cycles(40);
    check(8'h00, {7'h0, sckOe});
    bus_rd(8'h4d, 1'b0, 8'h01);
    $display("disable test done");
    portEnable = 1'b1;
    controllerSelect = 1'b0;
    idleClockLevel = 1'b0;
    sampleEdgeSelect = 1'b0;
    ssIn_n = 1'b0;
    rb = 8'($random(seed));
    bus_wr(8'h4e, d, 1'b0);
    // external clock toggles every two system clocks
    for (i = 0; i < 16; i++) begin
      if (!i[0]) begin
        sdi = rb[7 - i / 2];
        got[7 - i / 2] = serialOut;
      end
      sIn = ~sIn;
      wait_cycles(2);
    end
    check(d, got);
    bus_rd(8'h4d, 1'b0, 8'h81);
    bus_rd(8'h4e, 1'b0, rb);
    bus_rd(8'h4d, 1'b0, 8'h01);
    ssIn_n = 1'b1;
    $display("slave test done");
    tally_and_finish;
  end
endmodule : testbench
